// ### logic/uhb_pkg.sv
// Purpose: Shared constants for the UART holding and baud divider block
// Assumes: 32-bit APB data, each register on its own aligned word
// Notes: Addresses are full byte addresses as decoded on paddr
package uhb_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned IRQ_W = 4;

  localparam logic [31:0] ADDR_RX_HOLD = 32'h400e0618;
  localparam logic [31:0] ADDR_TX_HOLD = 32'h400e061c;
  localparam logic [31:0] ADDR_BAUD_DIV = 32'h400e0620;
  localparam logic [31:0] ADDR_CONTROL = 32'h400e0624;
  localparam logic [31:0] ADDR_STATUS = 32'h400e0628;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h400e062c;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h400e0630;

  // Control register fields
  localparam int unsigned CTL_RX_EN = 0;
  localparam int unsigned CTL_TX_EN = 1;

  // Status register fields
  localparam int unsigned ST_RX_AVAIL = 0;
  localparam int unsigned ST_TX_FREE = 1;
  localparam int unsigned ST_DMA_EMPTY = 11;
  localparam int unsigned ST_DMA_FULL = 12;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_RX_AVAIL = 0;
  localparam int unsigned IRQ_TX_FREE = 1;
  localparam int unsigned IRQ_DMA_EMPTY = 2;
  localparam int unsigned IRQ_DMA_FULL = 3;

  localparam logic [15:0] RST_BAUD_DIV = 16'h0000;
  localparam logic [1:0] RST_CONTROL = 2'h0;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
endpackage

// ### logic/uhb_baud_gen.sv
// Purpose: Oversampling tick generator for the baud clock
// Assumes: Divisor comes from a register on the same clock
// Notes: One tick every divisor cycles, sixteen ticks per bit
`timescale 1ns/1ps
`default_nettype none
module uhb_baud_gen #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] baud_divisor,
  output logic sample_tick
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic next_tick;

  // Divisor zero clears the counter and stops all ticks
  always_comb begin
    next_count = '0;
    next_tick = 1'b0;
    if (baud_divisor != '0) begin
      if (count >= baud_divisor - 1'b1) begin
        next_count = '0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      sample_tick <= 1'b0;
    end else begin
      count <= next_count;
      sample_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### logic/uhb_top.sv
// Purpose: Character holding registers and baud divider of a UART, on APB
// Assumes: Shifters and DMA channel run on pclk, so no synchronisers
// Notes: Zero wait state slave; every output is a flip-flop
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module uhb_top
  import uhb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHAR_W-1:0] rx_char_in,
  input wire logic rx_char_strobe,
  input wire logic tx_shift_load,
  output logic [CHAR_W-1:0] character_to_send,
  output logic tx_char_pending,
  output logic baud_sample_tick,
  input wire logic tx_dma_empty,
  input wire logic rx_dma_full,
  output logic irq
);
  // Register state
  logic [DIV_W-1:0] baud_divisor;
  logic [DIV_W-1:0] next_baud_divisor;
  logic [1:0] control;
  logic [1:0] next_control;
  logic [CHAR_W-1:0] received_character;
  logic [CHAR_W-1:0] next_received_character;
  logic rx_char_available;
  logic next_rx_char_available;
  logic [CHAR_W-1:0] next_character_to_send;
  logic next_tx_char_pending;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic tx_free_prev;
  logic dma_empty_prev;
  logic dma_full_prev;
  logic next_irq;
  // Bus state
  logic [DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  // Decoded strobes
  logic setup;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic tx_holding_free;
  logic [IRQ_W-1:0] irq_events;
  logic tick_raw;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_RX_HOLD) || (a == ADDR_TX_HOLD) ||
                  (a == ADDR_BAUD_DIV) || (a == ADDR_CONTROL) ||
                  (a == ADDR_STATUS) || (a == ADDR_IRQ_STATUS) ||
                  (a == ADDR_IRQ_MASK);
  endfunction

  uhb_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .baud_divisor(baud_divisor),
    .sample_tick(tick_raw)
  );

  // Bus phases; the answer is prepared during setup so pready is a flop
  assign setup = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite && !pslverr;
  assign rd_done = access_done && !pwrite && !pslverr;

  // Space for a new character exists only with the transmitter on
  assign tx_holding_free = control[CTL_TX_EN] && !tx_char_pending;

  // Hardware events; the free event marks a rising edge of the flag
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_RX_AVAIL] = rx_char_strobe && control[CTL_RX_EN];
    irq_events[IRQ_TX_FREE] = tx_holding_free && !tx_free_prev;
    irq_events[IRQ_DMA_EMPTY] = tx_dma_empty && !dma_empty_prev;
    irq_events[IRQ_DMA_FULL] = rx_dma_full && !dma_full_prev;
  end

  // Read data, ready and error for the coming access phase
  always_comb begin
    next_prdata = '0;
    next_pready = setup;
    next_pslverr = setup && !addr_mapped(paddr);
    if (setup && !pwrite) begin
      if (paddr == ADDR_RX_HOLD) begin
        next_prdata[CHAR_W-1:0] = received_character;
      end else if (paddr == ADDR_BAUD_DIV) begin
        next_prdata[DIV_W-1:0] = baud_divisor;
      end else if (paddr == ADDR_CONTROL) begin
        next_prdata[1:0] = control;
      end else if (paddr == ADDR_STATUS) begin
        next_prdata[ST_RX_AVAIL] = rx_char_available;
        next_prdata[ST_TX_FREE] = tx_holding_free;
        next_prdata[ST_DMA_EMPTY] = tx_dma_empty;
        next_prdata[ST_DMA_FULL] = rx_dma_full;
      end else if (paddr == ADDR_IRQ_STATUS) begin
        next_prdata[IRQ_W-1:0] = irq_status;
      end else if (paddr == ADDR_IRQ_MASK) begin
        next_prdata[IRQ_W-1:0] = irq_mask;
      end
    end
  end

  // Software writable configuration
  always_comb begin
    next_baud_divisor = baud_divisor;
    next_control = control;
    next_irq_mask = irq_mask;
    if (wr_done) begin
      if (paddr == ADDR_BAUD_DIV) begin
        next_baud_divisor = pwdata[DIV_W-1:0];
      end else if (paddr == ADDR_CONTROL) begin
        next_control = pwdata[1:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        next_irq_mask = pwdata[IRQ_W-1:0];
      end
    end
  end

  // Receive holding; a new character wins over a read in the same cycle
  always_comb begin
    next_received_character = received_character;
    next_rx_char_available = rx_char_available;
    if (rd_done && paddr == ADDR_RX_HOLD) begin
      next_rx_char_available = 1'b0;
    end
    if (rx_char_strobe && control[CTL_RX_EN]) begin
      next_received_character = rx_char_in;
      next_rx_char_available = 1'b1;
    end
    if (!control[CTL_RX_EN]) begin
      next_rx_char_available = 1'b0;
    end
  end

  // Transmit holding; writes without space are dropped, keeping the
  // waiting character intact rather than corrupting it mid-hand-over
  always_comb begin
    next_character_to_send = character_to_send;
    next_tx_char_pending = tx_char_pending;
    if (tx_shift_load) begin
      next_tx_char_pending = 1'b0;
    end
    if (wr_done && paddr == ADDR_TX_HOLD && tx_holding_free) begin
      next_character_to_send = pwdata[CHAR_W-1:0];
      next_tx_char_pending = 1'b1;
    end
    if (!control[CTL_TX_EN]) begin
      next_tx_char_pending = 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, events win over clears
  always_comb begin
    next_irq_status = irq_status;
    if (wr_done && paddr == ADDR_IRQ_STATUS) begin
      next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    next_irq = |(irq_status & irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      baud_divisor <= RST_BAUD_DIV;
      control <= RST_CONTROL;
      irq_mask <= RST_IRQ_MASK;
      received_character <= '0;
      rx_char_available <= 1'b0;
      character_to_send <= '0;
      tx_char_pending <= 1'b0;
      irq_status <= '0;
      irq <= 1'b0;
      tx_free_prev <= 1'b0;
      dma_empty_prev <= 1'b0;
      dma_full_prev <= 1'b0;
      baud_sample_tick <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      baud_divisor <= next_baud_divisor;
      control <= next_control;
      irq_mask <= next_irq_mask;
      received_character <= next_received_character;
      rx_char_available <= next_rx_char_available;
      character_to_send <= next_character_to_send;
      tx_char_pending <= next_tx_char_pending;
      irq_status <= next_irq_status;
      irq <= next_irq;
      tx_free_prev <= tx_holding_free;
      dma_empty_prev <= tx_dma_empty;
      dma_full_prev <= rx_dma_full;
      baud_sample_tick <= tick_raw;
    end
  end
endmodule
`default_nettype wire

// ### verif/uhb_checker.sv
// Purpose: Port level assertions for the holding and baud divider block
// Assumes: Zero wait state APB, answer in the cycle after setup
// Notes: Attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module uhb_checker
  import uhb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_shift_load,
  input wire logic [CHAR_W-1:0] character_to_send,
  input wire logic tx_char_pending,
  input wire logic tx_dma_empty,
  input wire logic rx_dma_full
);
  logic status_read;
  // Access cycle of a status read, where the flag bits stand
  assign status_read = pready && !pwrite && paddr == ADDR_STATUS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // DMA levels are taken at setup, so compare with the cycle before
  a_dma_empty_flag: assert property (status_read
    |-> prdata[ST_DMA_EMPTY] == $past(tx_dma_empty))
    else $error("dma empty");
  a_dma_full_flag: assert property (status_read
    |-> prdata[ST_DMA_FULL] == $past(rx_dma_full))
    else $error("dma full");
  a_rx_upper_zero: assert property (pready && paddr == ADDR_RX_HOLD
    |-> prdata[31:8] == 24'h0) else $error("rx upper bits");
  a_tx_accept: assert property ($rose(tx_char_pending) |->
    $past(psel && penable && pwrite && paddr == ADDR_TX_HOLD) &&
    {24'h0, character_to_send} == ($past(pwdata) & 32'hff))
    else $error("tx accept");
  a_load_drops_pending: assert property (
    tx_char_pending && tx_shift_load |=> !tx_char_pending)
    else $error("pending stuck");
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready long");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("idle bus busy");
  c_error: cover property (pready && pslverr);
  c_tx_take: cover property ($rose(tx_char_pending));
  c_load: cover property (tx_shift_load && tx_char_pending);
endmodule
`default_nettype wire

// ### verif/uhb_line_model.sv
// Purpose: Shifter side model: takes transmit characters, sends received
// Assumes: Same clock as the block; stall holds off the transmit shifter
// Notes: Idle receive data shows the inverse of the last character
`timescale 1ns/1ps
`default_nettype none
module uhb_line_model
  import uhb_pkg::*;
(
  input wire logic pclk,
  input wire logic stall,
  input wire logic tx_char_pending,
  input wire logic [CHAR_W-1:0] character_to_send,
  output logic tx_shift_load,
  output logic [CHAR_W-1:0] rx_char_in,
  output logic rx_char_strobe,
  output logic [CHAR_W-1:0] sent
);
  initial begin
    tx_shift_load = 1'b0;
    rx_char_in = 8'h00;
    rx_char_strobe = 1'b0;
    sent = 8'h00;
  end
  // One load pulse per waiting character, held off while stalled
  always @(posedge pclk) begin
    tx_shift_load <= tx_char_pending && !stall && !tx_shift_load;
    if (tx_shift_load)
      sent <= character_to_send;
  end
  // A character is valid for one cycle only, then scrambled
  task automatic send(input logic [CHAR_W-1:0] c);
    @(posedge pclk);
    rx_char_in <= c;
    rx_char_strobe <= 1'b1;
    @(posedge pclk);
    rx_char_in <= ~c;
    rx_char_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_uart_holding_and_baud_divider.sv
// Purpose: Self-checking bench for the holding registers and baud divider
// Assumes: APB master waits for pready; shifter model on the far side
// Notes: Flags are read back over APB after each event
`timescale 1ns/1ps
`default_nettype none
module tb_uart_holding_and_baud_divider
  import uhb_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic tx_dma_empty = 1'b0;
  logic rx_dma_full = 1'b0;
  logic stall = 1'b1;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, tx_shift_load, rx_char_strobe;
  logic tx_char_pending, baud_sample_tick, irq;
  logic [7:0] rx_char_in, character_to_send, sent;
  int fails = 0;
  int total_checks = 0;
  always #25 pclk = ~pclk;
  uhb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char_in(rx_char_in), .rx_char_strobe(rx_char_strobe),
    .tx_shift_load(tx_shift_load), .character_to_send(character_to_send),
    .tx_char_pending(tx_char_pending), .baud_sample_tick(baud_sample_tick),
    .tx_dma_empty(tx_dma_empty), .rx_dma_full(rx_dma_full), .irq(irq));
  uhb_line_model line (.pclk(pclk), .stall(stall),
    .tx_char_pending(tx_char_pending), .character_to_send(character_to_send),
    .tx_shift_load(tx_shift_load), .rx_char_in(rx_char_in),
    .rx_char_strobe(rx_char_strobe), .sent(sent));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Request held until pready is sampled high; only the watchdog ends it
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Interrupt output lags the register by one cycle
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  task automatic t_regs();
    apb(1'b0, ADDR_BAUD_DIV, 32'h0);
    chk(r, {16'h0, RST_BAUD_DIV});
    apb(1'b1, ADDR_BAUD_DIV, 32'hffff1234);
    apb(1'b0, ADDR_BAUD_DIV, 32'h0);
    chk(r, 32'h1234);
    apb(1'b0, ADDR_TX_HOLD, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 32'h400e0640, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_dma();
    for (int i = 0; i < 4; i++) begin
      tx_dma_empty <= i[0];
      rx_dma_full <= i[1];
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r & 32'h800, {20'h0, i[0], 11'h0});
      chk(r & 32'h1000, {19'h0, i[1], 12'h0});
    end
    // Each rising DMA level leaves its sticky bit behind
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(r, 32'h0000000c);
    $display("t_dma done");
  endtask
  task automatic t_rx();
    apb(1'b1, ADDR_CONTROL, 32'h1);
    line.send(8'ha5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h1, 32'h1);
    apb(1'b0, ADDR_RX_HOLD, 32'h0);
    chk(r, 32'ha5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h1, 32'h0);
    line.send(8'h3c);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h1, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'hf);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    line.send(8'h81);
    irq_is(1'b1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    irq_is(1'b0);
    $display("t_rx done");
  endtask
  task automatic t_tx();
    apb(1'b1, ADDR_CONTROL, 32'h2);
    // Receiver is off here, so this character must be ignored
    line.send(8'h77);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h2, 32'h2);
    chk(r & 32'h1, 32'h0);
    apb(1'b0, ADDR_RX_HOLD, 32'h0);
    chk(r, 32'h81);
    // Enabling the transmitter raises holding free once
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, ADDR_TX_HOLD, 32'h1ff5a);
    apb(1'b1, ADDR_TX_HOLD, 32'h33);
    chk({24'h0, character_to_send}, 32'h5a);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h2, 32'h0);
    stall <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({24'h0, sent}, 32'h5a);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h2, 32'h2);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r & 32'h2, 32'h0);
    $display("t_tx done");
  endtask
  // Counting whole periods makes the result independent of phase
  task automatic ticks(input logic [31:0] d, input int k, input int x);
    int n;
    n = 0;
    apb(1'b1, ADDR_BAUD_DIV, d);
    repeat (10) @(posedge pclk);
    repeat (k) begin
      @(posedge pclk);
      if (baud_sample_tick === 1'b1)
        n++;
    end
    chk(n, x);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dma();
    t_rx();
    t_tx();
    ticks(32'h3, 96, 32);
    ticks(32'h1, 16, 16);
    ticks(32'h10, 160, 10);
    ticks(32'h0, 48, 0);
    $display("t_baud done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule
bind uhb_top uhb_checker chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_shift_load(tx_shift_load), .character_to_send(character_to_send),
  .tx_char_pending(tx_char_pending), .tx_dma_empty(tx_dma_empty),
  .rx_dma_full(rx_dma_full));
`default_nettype wire
